// File: rtl/sfcfe_consts.svh
// Purpose: Constants of the serial flash command front end
// Assumes: Included by the top module
// Notes:   Opcodes, array geometry and cycle counts
`ifndef SFCFE_CONSTS_SVH
`define SFCFE_CONSTS_SVH
`define SFCFE_OP_ARM    8'h06
`define SFCFE_OP_DISARM 8'h04
`define SFCFE_OP_SRD    8'h05
`define SFCFE_OP_SWR    8'h01
`define SFCFE_OP_IDENT  8'h9F
`define SFCFE_OP_RD     8'h03
`define SFCFE_OP_FRD    8'h0B
`define SFCFE_OP_PGM    8'h02
`define SFCFE_OP_SWIPE  8'hD8
`define SFCFE_OP_FWIPE  8'hC7
`define SFCFE_OP_SLEEP  8'hB9
`define SFCFE_OP_WAKE   8'hAB
`define SFCFE_COL_LAST  8'hFF
`define SFCFE_SECT_LAST 16'hFFFF
`define SFCFE_SECT_TOP  4'hF
`define SFCFE_ID_LEN    20'h00014
`define SFCFE_SRW_LAST  20'h0000F
`endif

// File: rtl/sfcfe_pkg.sv
// Purpose: Types of the serial flash command front end
// Assumes: Constants come from the guarded header
// Notes:   Link capture state and array write port travel as structs
package sfcfe_pkg;
    // Execution states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_SRW  = 5'h02,
        ST_PRD  = 5'h04,
        ST_PWR  = 5'h08,
        ST_ERS  = 5'h10
    } sfcfe_st_t;

    // Array write port
    typedef struct packed {
        logic        we;
        logic [19:0] addr;
        logic [7:0]  data;
    } sfcfe_wr_t;

    // Link side capture of one frame
    typedef struct packed {
        logic [7:0]  op;
        logic [7:0]  sh;
        logic [7:0]  wsr;
        logic [19:0] addr;
        logic [2:0]  bits;
        logic [2:0]  byts;
        logic        tg;
    } sfcfe_lk_t;
endpackage

// File: rtl/sfcfe_top.sv
// Purpose: Command front end of a serial NOR flash on a four-wire link
// Assumes: Select high for at least 4 CLK periods between frames
// Notes:   Link logic runs on SCK; execution and array writes on CLK
`include "sfcfe_consts.svh"
module sfcfe_top #(
    parameter logic [7:0]       WAKE_SIG = 8'h5A,         // Arbitrary value
    parameter logic [0:19][7:0] ID_DATA  = {20{8'hC3}}    // Arbitrary value
) (
    input  wire logic              CLK,
    input  wire logic              RST_B,
    input  wire logic              SCK,
    input  wire logic              S_B,
    input  wire logic              SI,
    output logic                   SO,
    output logic                   SO_OE,
    output logic [19:0]            RD_ADDR,
    input  wire logic [7:0]        RD_DATA,
    output sfcfe_pkg::sfcfe_wr_t   ARR_WR,
    input  wire logic [7:0]        ARR_RDATA,
    output logic                   CYCLE_ACTIVE,
    output logic                   WRITE_ARM,
    output logic                   DEEP_SLEEP
);
    import sfcfe_pkg::*;

    logic [1:0]  rsync_q;
    logic        rst_n;
    logic        lrst;
    logic        fresh_q;
    sfcfe_lk_t   lk_q;
    sfcfe_lk_t   lk_d;
    logic [7:0]  buf_q [256];
    logic [7:0]  buf_d [256];
    logic [255:0] vld_q;
    logic [255:0] vld_d;
    logic [7:0]  byte_v;
    logic        has_addr;
    logic [8:0]  ls1_q;
    logic [8:0]  ls2_q;
    logic        busy_l;
    logic        slp_l;
    logic        out_en;
    logic [7:0]  obyte;
    logic        so_q;
    logic        so_d;
    logic        oe_q;
    logic        cs1_q;
    logic        cs2_q;
    logic        cs3_q;
    logic        tg1_q;
    logic        tg2_q;
    logic        seen_q;
    logic [8:0]  xs_q;
    logic        end_ev;
    logic        aligned;
    logic        busy;
    sfcfe_st_t   st_q;
    sfcfe_st_t   st_d;
    logic        wel_q;
    logic        wel_d;
    logic        slp_q;
    logic        slp_d;
    logic        all_q;
    logic        all_d;
    logic [3:0]  sr_q;
    logic [3:0]  sr_d;
    logic [19:0] cnt_q;
    logic [19:0] cnt_d;
    sfcfe_wr_t   wr_q;
    sfcfe_wr_t   wr_d;

    // Reset release through two flops
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rsync_q <= 2'h0;
        end else begin
            rsync_q <= {rsync_q[0], 1'h1};
        end
    end
    assign rst_n = rsync_q[1];
    assign lrst  = S_B | ~rst_n;   // Deselect ends any output

    // Marks the first rising edge of a frame
    always_ff @(posedge SCK or posedge lrst) begin
        if (lrst) begin
            fresh_q <= 1'h1;
        end else begin
            fresh_q <= 1'h0;
        end
    end

    // Status and sleep carried into the link domain
    assign busy_l   = ls2_q[0];
    assign slp_l    = ls2_q[8];
    assign byte_v   = {lk_q.sh[6:0], SI};
    assign has_addr = (lk_q.op == `SFCFE_OP_RD) || (lk_q.op == `SFCFE_OP_FRD) ||
                      (lk_q.op == `SFCFE_OP_PGM) || (lk_q.op == `SFCFE_OP_SWIPE);

    // Output phase per opcode; unknown codes never drive
    always_comb begin
        out_en = 1'h0;
        obyte  = RD_DATA;
        if (lk_q.op == `SFCFE_OP_WAKE) begin
            out_en = (lk_q.byts >= 3'h4);
            obyte  = WAKE_SIG;
        end else if (!slp_l) begin
            case (lk_q.op)
                `SFCFE_OP_RD: begin
                    out_en = !busy_l && (lk_q.byts >= 3'h4);
                end
                `SFCFE_OP_FRD: begin
                    out_en = !busy_l && (lk_q.byts >= 3'h5);
                end
                `SFCFE_OP_SRD: begin
                    out_en = (lk_q.byts != 3'h0);
                    obyte  = ls2_q[7:0];
                end
                `SFCFE_OP_IDENT: begin
                    out_en = !busy_l && (lk_q.byts != 3'h0) &&
                             (lk_q.addr < `SFCFE_ID_LEN);
                    obyte  = ID_DATA[lk_q.addr[4:0]];
                end
                default: begin
                    out_en = 1'h0;
                end
            endcase
        end
    end

    // Shift in opcode, address and data on rising edges
    always_comb begin
        lk_d  = lk_q;
        buf_d = buf_q;
        vld_d = vld_q;
        if (fresh_q) begin
            lk_d.bits = 3'h1;
            lk_d.byts = 3'h0;
            lk_d.sh   = {7'h00, SI};
            lk_d.addr = 20'h00000;
        end else begin
            lk_d.bits = lk_q.bits + 3'h1;
            lk_d.sh   = byte_v;
            if (lk_q.bits == 3'h7) begin
                if (lk_q.byts != 3'h7) begin
                    lk_d.byts = lk_q.byts + 3'h1;
                end
                if (lk_q.byts == 3'h0) begin
                    lk_d.op = byte_v;
                    lk_d.tg = ~lk_q.tg;
                    // New page only once the opcode is known; a cycle keeps its page
                    if (byte_v == `SFCFE_OP_PGM && !busy_l) begin
                        vld_d = '0;
                    end
                end else if (has_addr && lk_q.byts <= 3'h3) begin
                    lk_d.addr = {lk_q.addr[11:0], byte_v};
                end else if (lk_q.op == `SFCFE_OP_PGM) begin
                    if (!busy_l) begin
                        buf_d[lk_q.addr[7:0]] = byte_v;
                        vld_d[lk_q.addr[7:0]] = 1'h1;
                    end
                    lk_d.addr[7:0] = lk_q.addr[7:0] + 8'h01;  // Column wraps in page
                end else if (lk_q.op == `SFCFE_OP_SWR && lk_q.byts == 3'h1) begin
                    lk_d.wsr = byte_v;
                end else if (out_en) begin
                    lk_d.addr = lk_q.addr + 20'h00001;
                end
            end
        end
    end

    always_ff @(posedge SCK or negedge rst_n) begin
        if (!rst_n) begin
            lk_q  <= '0;
            vld_q <= '0;
            ls1_q <= 9'h000;
            ls2_q <= 9'h000;
        end else begin
            lk_q  <= lk_d;
            vld_q <= vld_d;
            ls1_q <= xs_q;
            ls2_q <= ls1_q;
        end
    end

    // Page buffer holds data only
    always_ff @(posedge SCK) begin
        buf_q <= buf_d;
    end

    // Output bit on falling edges, MSB first
    assign so_d = obyte[3'h7 - lk_q.bits];
    always_ff @(negedge SCK or posedge lrst) begin
        if (lrst) begin
            so_q <= 1'h0;
            oe_q <= 1'h0;
        end else begin
            so_q <= so_d;
            oe_q <= out_en;
        end
    end

    // Select, frame toggle and status word crossings
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            cs1_q  <= 1'h1;
            cs2_q  <= 1'h1;
            cs3_q  <= 1'h1;
            tg1_q  <= 1'h0;
            tg2_q  <= 1'h0;
            seen_q <= 1'h0;
            xs_q   <= 9'h000;
        end else begin
            cs1_q  <= S_B;
            cs2_q  <= cs1_q;
            cs3_q  <= cs2_q;
            tg1_q  <= lk_q.tg;
            tg2_q  <= tg1_q;
            seen_q <= end_ev ? tg2_q : seen_q;
            xs_q   <= {slp_q, sr_q[3], 2'h0, sr_q[2:0], wel_q, busy};
        end
    end
    assign end_ev  = cs2_q && !cs3_q && (tg2_q != seen_q);
    assign aligned = (lk_q.bits == 3'h0);
    assign busy    = (st_q != ST_IDLE) || wr_q.we;

    // Execute a frame when select rises
    always_comb begin
        st_d  = st_q;
        wel_d = wel_q;
        slp_d = slp_q;
        sr_d  = sr_q;
        all_d = all_q;
        cnt_d = cnt_q;
        wr_d  = '{we: 1'h0, addr: wr_q.addr, data: wr_q.data};
        case (st_q)
            ST_IDLE: begin
                if (end_ev) begin
                    if (lk_q.op == `SFCFE_OP_WAKE) begin
                        slp_d = 1'h0;
                    end else if (!slp_q && aligned) begin
                        case (lk_q.op)
                            `SFCFE_OP_ARM: begin
                                wel_d = wel_q | (lk_q.byts == 3'h1);
                            end
                            `SFCFE_OP_DISARM: begin
                                wel_d = wel_q & (lk_q.byts != 3'h1);
                            end
                            `SFCFE_OP_SLEEP: begin
                                slp_d = (lk_q.byts == 3'h1);
                            end
                            `SFCFE_OP_SWR: begin
                                if (wel_q && lk_q.byts == 3'h2) begin
                                    sr_d  = {lk_q.wsr[7], lk_q.wsr[4:2]};
                                    cnt_d = 20'h00000;
                                    st_d  = ST_SRW;
                                end
                            end
                            `SFCFE_OP_PGM: begin
                                if (wel_q && lk_q.byts >= 3'h5) begin
                                    cnt_d = {lk_q.addr[19:8], 8'h00};  // Page held in core domain
                                    st_d  = ST_PRD;
                                end
                            end
                            `SFCFE_OP_SWIPE: begin
                                if (wel_q && lk_q.byts == 3'h4) begin
                                    cnt_d = {lk_q.addr[19:16], 16'h0000};
                                    all_d = 1'h0;
                                    st_d  = ST_ERS;
                                end
                            end
                            `SFCFE_OP_FWIPE: begin
                                if (wel_q && lk_q.byts == 3'h1) begin
                                    cnt_d = 20'h00000;
                                    all_d = 1'h1;
                                    st_d  = ST_ERS;
                                end
                            end
                            default: begin
                                st_d = ST_IDLE;
                            end
                        endcase
                    end
                end
            end
            ST_SRW: begin
                cnt_d = cnt_q + 20'h00001;
                if (cnt_q == `SFCFE_SRW_LAST) begin
                    wel_d = 1'h0;
                    st_d  = ST_IDLE;
                end
            end
            ST_PRD: begin
                wr_d.addr = cnt_q;
                st_d      = ST_PWR;
            end
            ST_PWR: begin
                wr_d.we   = 1'h1;
                wr_d.data = ARR_RDATA & (vld_q[cnt_q[7:0]] ? buf_q[cnt_q[7:0]] : 8'hFF);
                cnt_d     = cnt_q + 20'h00001;
                st_d      = ST_PRD;
                if (cnt_q[7:0] == `SFCFE_COL_LAST) begin
                    wel_d = 1'h0;
                    st_d  = ST_IDLE;
                end
            end
            ST_ERS: begin
                wr_d.we   = 1'h1;
                wr_d.addr = cnt_q;
                wr_d.data = 8'hFF;
                cnt_d     = cnt_q + 20'h00001;
                if (cnt_q[15:0] == `SFCFE_SECT_LAST &&
                    (!all_q || cnt_q[19:16] == `SFCFE_SECT_TOP)) begin
                    wel_d = 1'h0;
                    st_d  = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            st_q  <= ST_IDLE;
            wel_q <= 1'h0;
            slp_q <= 1'h0;
            sr_q  <= 4'h0;
            all_q <= 1'h0;
            cnt_q <= 20'h00000;
            wr_q  <= '0;
        end else begin
            st_q  <= st_d;
            wel_q <= wel_d;
            slp_q <= slp_d;
            sr_q  <= sr_d;
            all_q <= all_d;
            cnt_q <= cnt_d;
            wr_q  <= wr_d;
        end
    end

    // Outputs
    assign SO           = so_q;
    assign SO_OE        = oe_q;
    assign RD_ADDR      = lk_q.addr;
    assign ARR_WR       = wr_q;
    assign CYCLE_ACTIVE = busy;
    assign WRITE_ARM    = wel_q;
    assign DEEP_SLEEP   = slp_q;

    // Checks on execution and output
    arm_set_a: assert property (@(posedge CLK) disable iff (!rst_n)
        end_ev && st_q == ST_IDLE && !slp_q && aligned &&
        lk_q.op == `SFCFE_OP_ARM && lk_q.byts == 3'h1 |=> wel_q)
        else $error("arm frame did not set latch");
    wel_clear_a: assert property (@(posedge CLK) disable iff (!rst_n)
        st_q != ST_IDLE && st_d == ST_IDLE |=> !wel_q)
        else $error("latch still set after cycle");
    no_arm_a: assert property (@(posedge CLK) disable iff (!rst_n)
        end_ev && st_q == ST_IDLE && !wel_q |=> st_q == ST_IDLE)
        else $error("cycle started without latch");
    pgm_clear_a: assert property (@(posedge CLK) disable iff (!rst_n)
        st_q == ST_PWR |=> wr_q.we && (wr_q.data & ~$past(ARR_RDATA)) == 8'h00)
        else $error("program set a bit");
    ers_ones_a: assert property (@(posedge CLK) disable iff (!rst_n)
        st_q == ST_ERS |=> wr_q.we && wr_q.data == 8'hFF)
        else $error("erase wrote non ones");
    ers_sector_a: assert property (@(posedge CLK) disable iff (!rst_n)
        (st_q == ST_ERS && !all_q) ##1 (st_q == ST_ERS) |->
        cnt_q[19:16] == $past(cnt_q[19:16]))
        else $error("sector erase left its sector");
    frame_cut_a: assert property (@(posedge CLK) disable iff (!rst_n)
        end_ev && st_q == ST_IDLE && !aligned && lk_q.op != `SFCFE_OP_WAKE |=>
        $stable(wel_q) && $stable(slp_q) && st_q == ST_IDLE)
        else $error("unaligned frame executed");
    busy_hold_a: assert property (@(posedge CLK) disable iff (!rst_n)
        end_ev && st_q != ST_IDLE && st_d == st_q |=> $stable(slp_q) && $stable(wel_q))
        else $error("frame acted during cycle");
    sleep_gate_a: assert property (@(posedge CLK) disable iff (!rst_n)
        end_ev && slp_q && lk_q.op != `SFCFE_OP_WAKE |=> slp_q && st_q == ST_IDLE)
        else $error("command acted in sleep");
    rd_start_a: assert property (@(negedge SCK) disable iff (lrst)
        oe_q && lk_q.op == `SFCFE_OP_RD |-> lk_q.byts >= 3'h4)
        else $error("read drove before address");
    unk_quiet_a: assert property (@(negedge SCK) disable iff (lrst)
        oe_q |-> lk_q.op inside {`SFCFE_OP_RD, `SFCFE_OP_FRD, `SFCFE_OP_SRD,
                                 `SFCFE_OP_IDENT, `SFCFE_OP_WAKE})
        else $error("output for undriven opcode");
    pgm_run_c: cover property (@(posedge CLK) disable iff (!rst_n)
        st_q == ST_PWR && cnt_q[7:0] == `SFCFE_COL_LAST);
    full_ers_c: cover property (@(posedge CLK) disable iff (!rst_n)
        st_q == ST_ERS && all_q);
    sleep_c: cover property (@(posedge CLK) disable iff (!rst_n) $rose(slp_q));
    read_c: cover property (@(negedge SCK) disable iff (lrst)
        oe_q && lk_q.op == `SFCFE_OP_FRD);
endmodule

// File: tb/sfcfe_host.sv
// Purpose: Host controller model on the four-wire link
// Assumes: Link clock idles low, rises mid-bit, period 15 ns
// Notes:   Data line toggles while unused so no stale level lingers
module sfcfe_host (
    output logic     sck,
    output logic     s_b,
    output logic     si,
    input  wire logic so,
    input  wire logic so_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle link, clock stands still outside frames
    initial begin
        sck = 1'b0;
        s_b = 1'b1;
        si = 1'b0;
    end

    // One frame: nbits from the top of tx, then nrd bytes read back
    task automatic xfer(input logic [63:0] tx, input int nbits, input int nrd,
                        output logic [15:0] rx, output logic oe_any, output logic oe_all);
        rx = 16'h0000;
        oe_any = 1'b0;
        oe_all = 1'b1;
        s_b = 1'b0;
        #7.5;
        for (int i = 0; i < nbits + 8 * nrd; i++) begin
            si = (i < nbits) ? tx[63 - i] : ~si;
            #7.5 sck = 1'b1;
            if (i >= nbits) begin
                rx = {rx[14:0], so};
                oe_any = oe_any | so_oe;
                oe_all = oe_all & so_oe;
            end
            #7.5 sck = 1'b0;
        end
        #7.5 s_b = 1'b1;
        // Gap of six core clocks between frames
        repeat (20) #15 si = ~si;
    endtask
endmodule

// File: tb/sfcfe_top_bench.sv
// Purpose: Self-checking bench of the flash command front end
// Assumes: Byte array modelled here, erased to FFh at time zero except six seeded bytes
// Notes:   Table of plain frames first, then cycles and refusals
module sfcfe_top_bench import sfcfe_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct {
        logic [39:0] tx;
        int          nbits;
        int          nrd;
        logic [15:0] rx;
        logic        oe;
        logic        arm;
        logic        slp;
    } sfcfe_row_t;

    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        sck;
    logic        s_b;
    logic        si;
    logic        so;
    logic        so_oe;
    logic [19:0] rd_addr;
    logic [7:0]  rd_data;
    sfcfe_wr_t   arr_wr;
    logic [7:0]  arr_rdata;
    logic        cycle_active;
    logic        write_arm;
    logic        deep_sleep;
    logic [7:0]  mem [0:1048575];
    logic [15:0] rx;
    logic        oe_any;
    logic        oe_all;
    int          errors = 0;
    int          compares = 0;
    int          cycles = 0;
    sfcfe_row_t  rows [14] = '{
        '{40'h0600000000, 8, 0, 16'h0000, 1'b0, 1'b1, 1'b0},
        '{40'h0400000000, 8, 0, 16'h0000, 1'b0, 1'b0, 1'b0},
        '{40'h0600000000, 8, 0, 16'h0000, 1'b0, 1'b1, 1'b0},
        '{40'h019C000000, 16, 0, 16'h0000, 1'b0, 1'b0, 1'b0},
        '{40'h0500000000, 8, 2, 16'h9C9C, 1'b1, 1'b0, 1'b0},
        '{40'h9F00000000, 8, 2, 16'hC3C3, 1'b1, 1'b0, 1'b0},
        '{40'h03F1234500, 32, 2, 16'hA53C, 1'b1, 1'b0, 1'b0},
        '{40'h0BF1234500, 40, 2, 16'hA53C, 1'b1, 1'b0, 1'b0},
        '{40'hAB00000000, 32, 2, 16'h5A5A, 1'b1, 1'b0, 1'b0},
        '{40'hB900000000, 8, 0, 16'h0000, 1'b0, 1'b0, 1'b1},
        '{40'h0600000000, 8, 0, 16'h0000, 1'b0, 1'b0, 1'b1},
        '{40'h03F1234500, 32, 1, 16'h0000, 1'b0, 1'b0, 1'b1},
        '{40'hAB00000000, 8, 0, 16'h0000, 1'b0, 1'b0, 1'b0},
        '{40'h7700000000, 8, 2, 16'h0000, 1'b0, 1'b0, 1'b0}};

    sfcfe_top u_sfcfe_top (
        .CLK(clk), .RST_B(rst_b), .SCK(sck), .S_B(s_b), .SI(si), .SO(so), .SO_OE(so_oe),
        .RD_ADDR(rd_addr), .RD_DATA(rd_data), .ARR_WR(arr_wr), .ARR_RDATA(arr_rdata),
        .CYCLE_ACTIVE(cycle_active), .WRITE_ARM(write_arm), .DEEP_SLEEP(deep_sleep));
    sfcfe_host u_sfcfe_host (.sck(sck), .s_b(s_b), .si(si), .so(so), .so_oe(so_oe));

    // Array answers reads at once, takes writes on the core clock
    assign rd_data = mem[rd_addr];
    assign arr_rdata = mem[arr_wr.addr];
    always @(posedge clk) begin
        if (arr_wr.we === 1'b1) mem[arr_wr.addr] <= arr_wr.data;
    end

    always #25 clk = ~clk;

    task automatic tally_and_finish();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic send(input logic [63:0] tx, input int nbits, input int nrd);
        u_sfcfe_host.xfer(tx, nbits, nrd, rx, oe_any, oe_all);
    endtask

    // Bounded wait for the running cycle to end
    task automatic wait_idle(input int bound);
        for (int n = 0; n < bound && cycle_active !== 1'b0; n++) begin
            @(posedge clk);
            #1;
        end
        check("idle", cycle_active, 0);
    endtask

    // Hang guard, erase of one sector dominates the run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            errors++;
            $display("MISMATCH timeout expected idle seen running");
            tally_and_finish();
        end
    end

    initial begin
        for (int a = 0; a < 1048576; a++) mem[a] = 8'hFF;
        mem[20'h12345] = 8'hA5;
        mem[20'h12346] = 8'h3C;
        mem[20'h012FE] = 8'hF0;
        mem[20'hF0010] = 8'h00;
        mem[20'hEFFFF] = 8'h00;
        mem[20'hFFFFF] = 8'h12;
        repeat (2) @(posedge clk);
        #1;
        check("reset", {so_oe, cycle_active, write_arm, deep_sleep, arr_wr.we}, 0);
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        $display("reset test done");
        foreach (rows[k]) begin
            send({rows[k].tx, 24'h000000}, rows[k].nbits, rows[k].nrd);
            wait_idle(100);
            check("oe", rows[k].oe ? oe_all : oe_any, rows[k].oe);
            if (rows[k].oe) check("data", rx, rows[k].rx);
            check("arm", write_arm, rows[k].arm);
            check("sleep", deep_sleep, rows[k].slp);
            $display("row %0d done", k);
        end
        // Program wrapping inside the page, read refused meanwhile
        send({8'h06, 56'h0}, 8, 0);
        send({56'h020012FE3C810F, 8'h00}, 56, 0);
        check("busy", cycle_active, 1);
        send({32'h03012345, 32'h0}, 32, 1);
        check("refuse", oe_any, 0);
        wait_idle(1000);
        check("page", {mem[20'h012FE], mem[20'h012FF], mem[20'h01200]}, 24'h30810F);
        check("arm", write_arm, 0);
        $display("program test done");
        // Frames off the byte boundary and with the latch clear
        send({8'h06, 56'h0}, 8, 0);
        send({40'h0200120000, 24'h0}, 39, 0);
        check("short", {cycle_active, write_arm}, 2'b01);
        send({8'h04, 56'h0}, 9, 0);
        check("short", write_arm, 1);
        send({8'h04, 56'h0}, 8, 0);
        check("disarm", write_arm, 0);
        send({32'hD80F0010, 32'h0}, 32, 0);
        check("locked", cycle_active, 0);
        send({8'hC7, 56'h0}, 8, 0);
        check("locked", cycle_active, 0);
        $display("refusal test done");
        // Top sector erase, upper address nibble ignored
        send({8'h06, 56'h0}, 8, 0);
        send({32'hD8FF0010, 32'h0}, 32, 0);
        wait_idle(70000);
        check("wipe", {mem[20'hF0010], mem[20'hFFFFF], mem[20'hEFFFF]}, 24'hFFFF00);
        check("arm", write_arm, 0);
        $display("erase test done");
        // Reset in mid-run drops the latch
        send({8'h06, 56'h0}, 8, 0);
        check("arm", write_arm, 1);
        @(posedge clk);
        rst_b <= 1'b0;
        @(posedge clk);
        #1;
        check("rst arm", write_arm, 0);
        @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        $display("mid reset test done");
        tally_and_finish();
    end
endmodule
